// ==== src/tpw_pkg.sv ====
package tpw_pkg;
    localparam logic [31:0] CTRL_OFS = 32'h0000_0000;
    localparam logic [31:0] CMPA_OFS = 32'h0000_0004;
    localparam logic [31:0] CMPB_OFS = 32'h0000_0008;
    localparam logic [31:0] CAP_OFS = 32'h0000_000c;
    localparam logic [31:0] CNT_OFS = 32'h0000_0010;
    localparam logic [31:0] FLAG_OFS = 32'h0000_0014;

    // Control word fields
    localparam int MODE_LSB = 0;
    localparam int COMA_LSB = 4;
    localparam int COMB_LSB = 6;
    localparam int PRE_LSB = 8;
    localparam int DIRA_BIT = 11;
    localparam int DIRB_BIT = 12;
    // Flag word fields, write one to clear
    localparam int OVF_BIT = 0;
    localparam int CMPA_BIT = 1;
    localparam int CMPB_BIT = 2;
    localparam int CAPF_BIT = 3;

    localparam logic [15:0] MAX_VAL = 16'hffff;
    localparam logic [15:0] TOP8 = 16'h00ff;
    localparam logic [15:0] TOP9 = 16'h01ff;
    localparam logic [15:0] TOP10 = 16'h03ff;
    localparam logic [15:0] ZERO16 = 16'h0000;

    localparam logic [3:0] WM_CTC_A = 4'h4;
    localparam logic [3:0] WM_FP8 = 4'h5;
    localparam logic [3:0] WM_FP9 = 4'h6;
    localparam logic [3:0] WM_FP10 = 4'h7;
    localparam logic [3:0] WM_CTC_CAP = 4'hc;
    localparam logic [3:0] WM_FP_CAP = 4'he;
    localparam logic [3:0] WM_FP_A = 4'hf;

    localparam logic [1:0] COM_OFF = 2'h0;
    localparam logic [1:0] COM_TOG = 2'h1;
    localparam logic [1:0] COM_NINV = 2'h2;
    localparam logic [1:0] COM_INV = 2'h3;

    // Prescale select codes and divider limits
    localparam logic [2:0] PS_STOP = 3'h0;
    localparam logic [2:0] PS_1 = 3'h1;
    localparam logic [2:0] PS_8 = 3'h2;
    localparam logic [2:0] PS_64 = 3'h3;
    localparam logic [2:0] PS_256 = 3'h4;
    localparam logic [2:0] PS_1024 = 3'h5;
    localparam logic [9:0] DIV8_LAST = 10'h007;
    localparam logic [9:0] DIV64_LAST = 10'h03f;
    localparam logic [9:0] DIV256_LAST = 10'h0ff;
    localparam logic [9:0] DIV1024_LAST = 10'h3ff;

    localparam logic [12:0] CTRL_RST = 13'h0000;

    typedef struct packed {
        logic [3:0] waveform_mode_select;
        logic [1:0] channel_a_output_mode;
        logic [1:0] channel_b_output_mode;
        logic [2:0] prescale_sel;
        logic compare_a_pin_direction;
        logic compare_b_pin_direction;
    } tpw_ctrl_t;

    typedef struct packed {
        logic overflow_flag;
        logic compare_a_flag;
        logic compare_b_flag;
        logic capture_flag;
    } tpw_flags_t;

    typedef struct packed {
        tpw_ctrl_t ctrl;
        logic [15:0] compare_value_a;
        logic [15:0] compare_a_buffer;
        logic [15:0] compare_value_b;
        logic [15:0] compare_b_buffer;
        logic [15:0] capture_value_register;
        logic [15:0] counter_value;
        tpw_flags_t flags;
        logic [9:0] div_cnt;
        logic [1:0] out_lvl;
        logic [1:0] pin_out;
        logic [1:0] pin_oe;
        logic pready;
        logic [31:0] prdata;
    } tpw_state_t;
endpackage : tpw_pkg

// ==== src/tpw_timer.sv ====
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ps
// Contract
// - Modes 4 and 12 clear counter on match with compare A or capture value.
// - Clear-on-match sets compare A or capture flag when the ceiling is hit.
// - Clear-on-match ceiling unbuffered; write below count runs to max, wraps.
// - Clear-on-match, channel A mode 1 toggles output on every match.
// - Compare A output reaches its pin only while direction bit is one.
// - Clear-on-match sets overflow flag when counter rolls from max to zero.
// - Modes 5, 6, 7, 14, 15 count up zero to ceiling, then restart.
// - Fast PWM ceilings: 0xff, 0x1ff, 0x3ff, capture value, or compare A.
// - Non-inverting sets on match, clears at wrap; inverting does opposite.
// - Fast PWM output mode 2 is non-inverted, 3 is inverted.
// - Fast PWM sets a channel compare flag on every match.
// - Fast PWM sets overflow at ceiling, plus ceiling register's flag.
// - Fixed ceiling masks compare value bits above resolution on write.
// - No compare match occurs when compare value exceeds the ceiling.
// - Fast PWM capture ceiling unbuffered; low write runs to max, wraps.
// - Fast PWM compare writes buffered, loaded when counter hits ceiling.
// - Compare zero gives one-cycle spike; compare equal ceiling is constant.
// - Mode 15 with channel A mode 1 toggles A on each match.
// - Timer clock is core clock divided by 1, 8, 64, 256 or 1024.
// - Output mode zero takes no action; pin falls back to port control.
// - Output mode change switches pin source next cycle; level moves at next match or ceiling.
module tpw_timer (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [31:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] port_level,
    output logic [1:0] compare_pin_out,
    output logic [1:0] compare_pin_oe,
    output logic overflow_flag,
    output logic compare_a_flag
);
    tpw_pkg::tpw_state_t s_q;
    tpw_pkg::tpw_state_t s_d;
    logic pslverr_q;
    logic pslverr_d;
    tpw_pkg::tpw_flags_t hw_set;

    logic [15:0] top;
    logic fast_pwm;
    logic clear_on_match_mode;
    logic fixed_top;
    logic [15:0] res_mask;
    logic tick;
    logic at_top;
    logic at_max;
    logic [1:0] match;
    logic [1:0] com_eff;
    logic wr;
    logic rd;
    logic [15:0] wval;
    logic [9:0] div_last;
    logic [1:0] out_nxt;
    logic [1:0] dir_bits;

    always_comb begin
        unique case (s_q.ctrl.waveform_mode_select)
            tpw_pkg::WM_FP8: top = tpw_pkg::TOP8;
            tpw_pkg::WM_FP9: top = tpw_pkg::TOP9;
            tpw_pkg::WM_FP10: top = tpw_pkg::TOP10;
            tpw_pkg::WM_FP_CAP: top = s_q.capture_value_register;
            tpw_pkg::WM_CTC_CAP: top = s_q.capture_value_register;
            tpw_pkg::WM_CTC_A: top = s_q.compare_value_a;
            tpw_pkg::WM_FP_A: top = s_q.compare_value_a;
            default: top = tpw_pkg::MAX_VAL;
        endcase
    end

    assign clear_on_match_mode = (s_q.ctrl.waveform_mode_select == tpw_pkg::WM_CTC_A) ||
                 (s_q.ctrl.waveform_mode_select == tpw_pkg::WM_CTC_CAP);
    assign fixed_top = (s_q.ctrl.waveform_mode_select == tpw_pkg::WM_FP8) ||
                       (s_q.ctrl.waveform_mode_select == tpw_pkg::WM_FP9) ||
                       (s_q.ctrl.waveform_mode_select == tpw_pkg::WM_FP10);
    assign fast_pwm = fixed_top ||
                      (s_q.ctrl.waveform_mode_select == tpw_pkg::WM_FP_CAP) ||
                      (s_q.ctrl.waveform_mode_select == tpw_pkg::WM_FP_A);
    assign res_mask = fixed_top ? top : tpw_pkg::MAX_VAL;

    always_comb begin
        unique case (s_q.ctrl.prescale_sel)
            tpw_pkg::PS_8: div_last = tpw_pkg::DIV8_LAST;
            tpw_pkg::PS_64: div_last = tpw_pkg::DIV64_LAST;
            tpw_pkg::PS_256: div_last = tpw_pkg::DIV256_LAST;
            tpw_pkg::PS_1024: div_last = tpw_pkg::DIV1024_LAST;
            default: div_last = 10'h000;
        endcase
    end
    assign tick = (s_q.ctrl.prescale_sel != tpw_pkg::PS_STOP) &&
                  (s_q.div_cnt >= div_last);

    // Exact equality means a ceiling below the count is simply missed
    assign at_top = (clear_on_match_mode || fast_pwm) && (s_q.counter_value == top);
    assign at_max = s_q.counter_value == tpw_pkg::MAX_VAL;
    assign match[0] = s_q.counter_value == s_q.compare_value_a;
    assign match[1] = s_q.counter_value == s_q.compare_value_b;
    assign com_eff = {s_q.ctrl.channel_b_output_mode[1],
                      s_q.ctrl.channel_a_output_mode[1]};

    assign wr = psel && penable && pwrite && !s_q.pready;
    assign rd = psel && penable && !pwrite && !s_q.pready;
    assign wval = pwdata[15:0];
    assign dir_bits = {s_q.ctrl.compare_b_pin_direction,
                       s_q.ctrl.compare_a_pin_direction};

    generate
        for (genvar ch = 0; ch < 2; ch++) begin : g_out
            logic [1:0] com;
            assign com = (ch == 0) ? s_q.ctrl.channel_a_output_mode
                                   : s_q.ctrl.channel_b_output_mode;
            always_comb begin
                out_nxt[ch] = s_q.out_lvl[ch];
                if (fast_pwm) begin
                    if (com == tpw_pkg::COM_NINV || com == tpw_pkg::COM_INV)
                    begin
                        // Match wins at ceiling, so compare equal top holds
                        if (match[ch]) begin
                            out_nxt[ch] = (com == tpw_pkg::COM_NINV);
                        end else if (at_top) begin
                            out_nxt[ch] = (com == tpw_pkg::COM_INV);
                        end
                    end else if (ch == 0 && com == tpw_pkg::COM_TOG &&
                                 s_q.ctrl.waveform_mode_select ==
                                 tpw_pkg::WM_FP_A && match[ch]) begin
                        out_nxt[ch] = !s_q.out_lvl[ch];
                    end
                end else if (clear_on_match_mode && com == tpw_pkg::COM_TOG && match[ch]) begin
                    out_nxt[ch] = !s_q.out_lvl[ch];
                end
            end
        end
    endgenerate

    always_comb begin
        s_d = s_q;
        pslverr_d = 1'b0;
        hw_set = '0;
        s_d.pready = 1'b0;
        s_d.div_cnt = tick ? 10'h000 : s_q.div_cnt + 10'h001;
        if (s_q.ctrl.prescale_sel == tpw_pkg::PS_STOP) begin
            s_d.div_cnt = 10'h000;
        end

        if (tick) begin
            if (at_top) begin
                s_d.counter_value = tpw_pkg::ZERO16;
            end else begin
                s_d.counter_value = s_q.counter_value + 16'h0001;
            end
            // A ceiling equal to max also rolls the count from max to zero
            if (clear_on_match_mode && at_max) begin
                hw_set.overflow_flag = 1'b1;
            end
            if (fast_pwm && at_top) begin
                hw_set.overflow_flag = 1'b1;
                s_d.compare_value_a = s_q.compare_a_buffer;
                s_d.compare_value_b = s_q.compare_b_buffer;
            end
            if (at_top && (clear_on_match_mode || fast_pwm)) begin
                if (s_q.ctrl.waveform_mode_select == tpw_pkg::WM_CTC_CAP ||
                    s_q.ctrl.waveform_mode_select == tpw_pkg::WM_FP_CAP) begin
                    hw_set.capture_flag = 1'b1;
                end
            end
            if (match[0]) begin
                hw_set.compare_a_flag = 1'b1;
            end
            if (match[1]) begin
                hw_set.compare_b_flag = 1'b1;
            end
            s_d.out_lvl = out_nxt;
        end

        // Outside fast PWM the active compare tracks the buffer, so a value
        // written in PWM with the timer held survives a mode change
        if (!fast_pwm) begin
            s_d.compare_value_a = s_q.compare_a_buffer;
            s_d.compare_value_b = s_q.compare_b_buffer;
        end

        if (wr) begin
            s_d.pready = 1'b1;
            unique case (paddr)
                tpw_pkg::CTRL_OFS: begin
                    if (pstrb[0]) begin
                        s_d.ctrl.waveform_mode_select = pwdata[3:0];
                        s_d.ctrl.channel_a_output_mode = pwdata[5:4];
                        s_d.ctrl.channel_b_output_mode = pwdata[7:6];
                    end
                    if (pstrb[1]) begin
                        s_d.ctrl.prescale_sel = pwdata[10:8];
                        s_d.ctrl.compare_a_pin_direction =
                            pwdata[tpw_pkg::DIRA_BIT];
                        s_d.ctrl.compare_b_pin_direction =
                            pwdata[tpw_pkg::DIRB_BIT];
                    end
                end
                tpw_pkg::CMPA_OFS: begin
                    s_d.compare_a_buffer = wval & res_mask;
                    if (!fast_pwm) begin
                        s_d.compare_value_a = wval & res_mask;
                    end
                end
                tpw_pkg::CMPB_OFS: begin
                    s_d.compare_b_buffer = wval & res_mask;
                    if (!fast_pwm) begin
                        s_d.compare_value_b = wval & res_mask;
                    end
                end
                tpw_pkg::CAP_OFS: begin
                    s_d.capture_value_register = wval;
                end
                tpw_pkg::CNT_OFS: begin
                    s_d.counter_value = wval;
                end
                tpw_pkg::FLAG_OFS: begin
                    // Write one clears; a hardware set merged below wins
                    if (pwdata[tpw_pkg::OVF_BIT]) begin
                        s_d.flags.overflow_flag = 1'b0;
                    end
                    if (pwdata[tpw_pkg::CMPA_BIT]) begin
                        s_d.flags.compare_a_flag = 1'b0;
                    end
                    if (pwdata[tpw_pkg::CMPB_BIT]) begin
                        s_d.flags.compare_b_flag = 1'b0;
                    end
                    if (pwdata[tpw_pkg::CAPF_BIT]) begin
                        s_d.flags.capture_flag = 1'b0;
                    end
                end
                default: pslverr_d = 1'b1;
            endcase
        end

        if (rd) begin
            s_d.pready = 1'b1;
            s_d.prdata = 32'h0000_0000;
            unique case (paddr)
                tpw_pkg::CTRL_OFS: begin
                    s_d.prdata[3:0] = s_q.ctrl.waveform_mode_select;
                    s_d.prdata[5:4] = s_q.ctrl.channel_a_output_mode;
                    s_d.prdata[7:6] = s_q.ctrl.channel_b_output_mode;
                    s_d.prdata[10:8] = s_q.ctrl.prescale_sel;
                    s_d.prdata[tpw_pkg::DIRA_BIT] =
                        s_q.ctrl.compare_a_pin_direction;
                    s_d.prdata[tpw_pkg::DIRB_BIT] =
                        s_q.ctrl.compare_b_pin_direction;
                end
                tpw_pkg::CMPA_OFS: s_d.prdata[15:0] = s_q.compare_a_buffer;
                tpw_pkg::CMPB_OFS: s_d.prdata[15:0] = s_q.compare_b_buffer;
                tpw_pkg::CAP_OFS: s_d.prdata[15:0] = s_q.capture_value_register;
                tpw_pkg::CNT_OFS: s_d.prdata[15:0] = s_q.counter_value;
                tpw_pkg::FLAG_OFS: begin
                    s_d.prdata[tpw_pkg::OVF_BIT] = s_q.flags.overflow_flag;
                    s_d.prdata[tpw_pkg::CMPA_BIT] = s_q.flags.compare_a_flag;
                    s_d.prdata[tpw_pkg::CMPB_BIT] = s_q.flags.compare_b_flag;
                    s_d.prdata[tpw_pkg::CAPF_BIT] = s_q.flags.capture_flag;
                end
                default: pslverr_d = 1'b1;
            endcase
        end

        // Hardware set lands after any clear, so the set wins in one cycle
        s_d.flags = tpw_pkg::tpw_flags_t'(s_d.flags | hw_set);

        // Pin drive: waveform when mode nonzero, else port level, gated by dir
        for (int i = 0; i < 2; i++) begin
            s_d.pin_oe[i] = dir_bits[i];
            s_d.pin_out[i] = com_eff[i] ||
                ((i == 0 ? s_q.ctrl.channel_a_output_mode[0]
                         : s_q.ctrl.channel_b_output_mode[0]))
                ? s_d.out_lvl[i] : port_level[i];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.ctrl <= tpw_pkg::tpw_ctrl_t'(tpw_pkg::CTRL_RST);
            pslverr_q <= 1'b0;
        end else begin
            s_q <= s_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = pslverr_q;
    assign compare_pin_out = s_q.pin_out;
    assign compare_pin_oe = s_q.pin_oe;
    assign overflow_flag = s_q.flags.overflow_flag;
    assign compare_a_flag = s_q.flags.compare_a_flag;
endmodule : tpw_timer

// ==== bench/tpw_timer_properties.sv ====
`timescale 1ns/1ps
module tpw_timer_checker (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [31:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [1:0] compare_pin_oe,
    input wire logic overflow_flag,
    input wire logic compare_a_flag
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire acc = psel && penable && pwrite && !pready;
    wire ctrl_wr = acc && paddr == tpw_pkg::CTRL_OFS;
    wire clr_ovf = acc && paddr == tpw_pkg::FLAG_OFS && pwdata[0];
    wire clr_cmpa = acc && paddr == tpw_pkg::FLAG_OFS && pwdata[1];
    wire mapped = paddr[1:0] == 2'h0 && paddr <= tpw_pkg::FLAG_OFS;
    logic [2:0] presc_q;
    // Tracks the prescale select so flag activity can be tied to it
    always_ff @(posedge core_clk) begin
        if (!rst_n) presc_q <= 3'h0;
        else if (ctrl_wr) presc_q <= pwdata[10:8];
    end
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    chk_ready_answer: assert property (psel && penable && !pready |=> pready)
        else $error("no answer one cycle after access");
    chk_err_decode: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr does not match address decode");
    chk_err_alone: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_pin_dir: assert property (
        ctrl_wr ##2 1 |-> compare_pin_oe == $past(pwdata[12:11], 2))
        else $error("pin enable differs from direction bits");
    chk_ovf_sticky: assert property ($fell(overflow_flag) |->
        $past(clr_ovf) || $past(clr_ovf, 2))
        else $error("overflow flag dropped without clear");
    chk_cmpa_sticky: assert property ($fell(compare_a_flag) |->
        $past(clr_cmpa) || $past(clr_cmpa, 2))
        else $error("compare flag dropped without clear");
    chk_ovf_tick: assert property ($rose(overflow_flag) |->
        presc_q != 3'h0 || $past(presc_q) != 3'h0)
        else $error("overflow flag set with timer stopped");
    chk_cmpa_tick: assert property ($rose(compare_a_flag) |->
        presc_q != 3'h0 || $past(presc_q) != 3'h0)
        else $error("compare flag set with timer stopped");
endmodule : tpw_timer_checker

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, er;
    logic [31:0] paddr, pwdata, prdata, rd, v;
    logic [3:0] pstrb;
    logic [1:0] port_level, compare_pin_out, compare_pin_oe;
    logic overflow_flag, compare_a_flag;
    logic [15:0] c;
    integer n_errors = 0, comparisons = 0, seed = 32'h25e5e7be, n, i, k;

    tpw_timer DUT (.core_clk(core_clk), .rst_n(rst_n), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .port_level(port_level), .compare_pin_out(compare_pin_out),
        .compare_pin_oe(compare_pin_oe), .overflow_flag(overflow_flag),
        .compare_a_flag(compare_a_flag));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task check(input string what, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check

    task test_done;
        $display("mismatches %0d, comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done

    task apb(input logic wr, input logic [31:0] a, d);
        integer t;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge core_clk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        if (t >= 50) n_errors++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task cfg(input logic [3:0] m, input logic [1:0] com, input logic [2:0] ps,
             input logic dir);
        apb(1'b1, tpw_pkg::CTRL_OFS, {20'h0, dir, ps, 2'h0, com, m});
    endtask : cfg

    // Cycles between two successive toggles of the channel A pin
    task gap(output integer cnt);
        logic lvl;
        for (k = 0; k < 2; k++) begin
            lvl = compare_pin_out[0];
            cnt = 0;
            while (compare_pin_out[0] === lvl && cnt < 10000) begin
                @(posedge core_clk);
                cnt++;
            end
        end
    endtask : gap

    // High cycles in one 256-cycle period of 8-bit fast PWM
    function automatic integer pwm_high(input logic inv,
        input logic [15:0] cmp);
        if (cmp == tpw_pkg::TOP8)
            return inv ? 0 : 256;
        return inv ? cmp + 1 : 255 - cmp;
    endfunction : pwm_high

    initial begin
        repeat (90000) @(posedge core_clk);
        n_errors++;
        test_done();
    end

    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'hf;
        port_level = 2'h0;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        check("outputs", {compare_pin_out, compare_pin_oe, overflow_flag,
              compare_a_flag}, 32'h0);
        apb(1'b0, 32'h0000_0018, 32'h0);
        check("unmapped err", er, 32'h1);
        check("unmapped data", rd, 32'h0);
        v = $random(seed) & 32'h0000_18ff;
        apb(1'b1, tpw_pkg::CTRL_OFS, v);
        apb(1'b0, tpw_pkg::CTRL_OFS, 32'h0);
        check("ctrl", rd, v);
        for (i = 0; i < 3; i++) begin
            c = $random(seed);
            cfg(tpw_pkg::WM_FP8 + i[3:0], 2'h0, 3'h0, 1'b0);
            apb(1'b1, tpw_pkg::CMPA_OFS, {16'h0, c});
            apb(1'b0, tpw_pkg::CMPA_OFS, 32'h0);
            check("cmpa mask", rd, {16'h0, c & ((16'h0100 << i) - 16'h1)});
        end
        apb(1'b1, tpw_pkg::CMPA_OFS, 32'h3);
        apb(1'b1, tpw_pkg::CAP_OFS, 32'h7);
        for (i = 1; i < 6; i++) begin
            cfg(tpw_pkg::WM_CTC_A, tpw_pkg::COM_TOG, i[2:0], 1'b1);
            gap(n);
            check("ctc gap", n, i < 4 ? 4 << 3 * (i - 1) : 4 << 2 * i);
        end
        cfg(tpw_pkg::WM_FP_A, tpw_pkg::COM_TOG, tpw_pkg::PS_1, 1'b1);
        gap(n);
        check("fast toggle gap", n, 32'd4);
        cfg(tpw_pkg::WM_CTC_CAP, tpw_pkg::COM_TOG, tpw_pkg::PS_1, 1'b1);
        gap(n);
        check("cap ctc gap", n, 32'd8);
        cfg(tpw_pkg::WM_CTC_A, tpw_pkg::COM_OFF, tpw_pkg::PS_1, 1'b0);
        repeat (10) @(posedge core_clk);
        port_level <= $random(seed);
        repeat (4) @(posedge core_clk);
        check("port level", compare_pin_out[0], port_level[0]);
        check("pin enable", compare_pin_oe[0], 32'h0);
        apb(1'b1, tpw_pkg::CMPA_OFS, 32'h5);
        apb(1'b1, tpw_pkg::CNT_OFS, 32'hfff0);
        apb(1'b1, tpw_pkg::FLAG_OFS, 32'hf);
        check("early flags", {overflow_flag, compare_a_flag}, 32'h0);
        repeat (20) @(posedge core_clk);
        check("wrap overflow", overflow_flag, 32'h1);
        repeat (10) @(posedge core_clk);
        check("ctc match flag", compare_a_flag, 32'h1);
        apb(1'b0, tpw_pkg::FLAG_OFS, 32'h0);
        check("flag read", {rd[3], rd[1:0]}, 32'h3);
        for (i = 0; i < 6; i++) begin
            c = i < 2 ? 16'h0 : i < 4 ? 16'h00ff : $random(seed) & 16'h00ff;
            apb(1'b1, tpw_pkg::CMPA_OFS, {16'h0, c});
            cfg(tpw_pkg::WM_FP8, i[0] ? tpw_pkg::COM_INV : tpw_pkg::COM_NINV,
                tpw_pkg::PS_1, 1'b1);
            repeat (600) @(posedge core_clk);
            n = 0;
            repeat (256) begin
                @(posedge core_clk);
                n += compare_pin_out[0] === 1'b1;
            end
            check("pwm high time", n, pwm_high(i[0], c));
        end
        apb(1'b1, tpw_pkg::FLAG_OFS, 32'hf);
        repeat (300) @(posedge core_clk);
        check("pwm flags", {overflow_flag, compare_a_flag}, 32'h3);
        cfg(tpw_pkg::WM_FP_CAP, tpw_pkg::COM_NINV, tpw_pkg::PS_1, 1'b1);
        apb(1'b1, tpw_pkg::CAP_OFS, 32'h10);
        apb(1'b1, tpw_pkg::CNT_OFS, 32'h0);
        apb(1'b1, tpw_pkg::CMPA_OFS, 32'h20);
        repeat (100) @(posedge core_clk);
        apb(1'b1, tpw_pkg::FLAG_OFS, 32'hf);
        repeat (100) @(posedge core_clk);
        check("no match above top", compare_a_flag, 32'h0);
        check("cap top overflow", overflow_flag, 32'h1);
        test_done();
    end
endmodule : testbench

bind tpw_timer tpw_timer_checker u_chk (.core_clk(core_clk), .rst_n(rst_n),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .compare_pin_oe(compare_pin_oe), .overflow_flag(overflow_flag),
    .compare_a_flag(compare_a_flag));
